// ===== verilog/qhp_port.sv
// Host bus port of a four-channel UART: strobe-style and direction-style modes.
// Assumes bus pins are asynchronous to CLK and the mode pin is static.
//
// Contract
// - In strobe mode a read strobe fall reads the register at the low address and drives it on the data bus.
// - In strobe mode a write strobe fall starts a write and its rise stores the data byte at the address.
// - In direction mode the write strobe pin means read when high and write when low.
// - In strobe mode each active-low channel select enables only its own channel.
// - In direction mode channel A select is the single active-low chip select.
// - In direction mode channel B and C selects become address bits 3 and 4 choosing the channel.
// - In strobe mode a channel interrupt pin is driven only when its modem control bit 3 is set.
// - In direction mode channel A interrupt becomes one open-drain active-low device interrupt.
// - In direction mode interrupts of channels B, C and D are held low.
// - In strobe mode the force input drives all interrupts regardless of bit 3.
// - The three low address bits pick one register of the addressed channel.
module qhp_port (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic STROBE_MODE,
  input wire logic [qhp_pkg::ADDR_W-1:0] ADDR,
  input wire logic [qhp_pkg::DATA_W-1:0] DATA_IN,
  output logic [qhp_pkg::DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic CHAN_A_SELECT_N,
  input wire logic CHAN_B_SELECT_N,
  input wire logic CHAN_C_SELECT_N,
  input wire logic CHAN_D_SELECT_N,
  input wire logic IRQ_FORCE_SELECT,
  input wire logic [qhp_pkg::NUM_CHAN-1:0] CHAN_IRQ_REQ,
  output logic [qhp_pkg::NUM_CHAN-1:0] CHAN_IRQ,
  output logic [qhp_pkg::NUM_CHAN-1:0] CHAN_IRQ_OE
);
  import qhp_pkg::*;

  localparam int NSYNC = 9;
  // Idle pin levels; force idles low so reset makes no false edge
  localparam logic [NSYNC-1:0] PIN_IDLE = 9'h1bf;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] cur;
    logic mode;
    logic mode_ok;
    logic [1:0] warm;
    qhp_state_e st;
    logic [MEM_AW-1:0] acc;
    logic [DATA_W-1:0] wbyte;
    logic [NUM_CHAN-1:0] irq_en;
    logic rd_pend;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic [NUM_CHAN-1:0] irq;
    logic [NUM_CHAN-1:0] irq_oe;
  } qhp_state_s;

  qhp_state_s r_q, r_d;
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [DATA_W-1:0] mem_rdata;
  logic [NSYNC-1:0] pins;

  // Pin bits: 0 rd_n, 1 wr_n, 2..5 sel A..D, 6 force, 7 mode, 8 unused spare
  assign pins = {1'b1, STROBE_MODE, IRQ_FORCE_SELECT, CHAN_D_SELECT_N, CHAN_C_SELECT_N,
                 CHAN_B_SELECT_N, CHAN_A_SELECT_N, WRITE_STROBE_N, READ_STROBE_N};

  // Channel index decode, used at the falling edge that opens each access
  function automatic logic [CHAN_W:0] chan_of(input logic mode, input logic [NSYNC-1:0] p);
    logic [CHAN_W:0] r;
    r = '0;
    if (mode) begin
      // Strobe mode: lowest active select wins, one-hot expected
      if (!p[2]) r = 3'b100;
      else if (!p[3]) r = 3'b101;
      else if (!p[4]) r = 3'b110;
      else if (!p[5]) r = 3'b111;
    end else if (!p[2]) begin
      // Address lines: the pin level is the bit itself
      r = {1'b1, p[4], p[3]};
    end
    return r;
  endfunction

  qhp_regmem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
    .clk(CLK),
    .we(mem_we),
    .waddr(r_q.acc),
    .wdata(r_q.wbyte),
    .raddr(mem_addr),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [NSYNC-1:0] stab;
  logic rd_fall, wr_fall, wr_rise, rd_rise, dir_start, dir_end;
  logic [CHAN_W:0] ch;
  always_comb begin
    r_d = r_q;
    r_d.s1 = pins;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    // Change counts once stages two and three agree
    stab = r_q.cur;
    for (int i = 0; i < NSYNC; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) stab[i] = r_q.s3[i];
    end
    r_d.cur = stab;
    ch = chan_of(r_q.mode, stab);
    mem_we = 1'b0;
    mem_addr = r_q.acc;
    // Mode taken once the synchroniser has refilled after reset, then frozen
    if (!r_q.mode_ok) begin
      if (r_q.warm == 2'h3) begin
        r_d.mode = stab[7];
        r_d.mode_ok = 1'b1;
      end else begin
        r_d.warm = r_q.warm + 2'h1;
      end
    end
    rd_fall = r_q.cur[0] & ~stab[0];
    rd_rise = ~r_q.cur[0] & stab[0];
    wr_fall = r_q.cur[1] & ~stab[1];
    wr_rise = ~r_q.cur[1] & stab[1];
    // Direction mode: access is framed by chip select A
    dir_start = r_q.cur[2] & ~stab[2];
    dir_end = ~r_q.cur[2] & stab[2];
    case (r_q.st)
      QHP_IDLE: begin
        if (r_q.mode_ok && r_q.mode && ch[CHAN_W]) begin
          if (rd_fall) begin
            r_d.acc = {ch[CHAN_W-1:0], ADDR};
            r_d.rd_pend = 1'b1;
            r_d.st = QHP_READ;
          end else if (wr_fall) begin
            r_d.acc = {ch[CHAN_W-1:0], ADDR};
            r_d.st = QHP_WRITE;
          end
        end else if (r_q.mode_ok && !r_q.mode && dir_start) begin
          // Read strobe and select D are ignored here
          r_d.acc = {ch[CHAN_W-1:0], ADDR};
          r_d.rd_pend = stab[1];
          r_d.st = stab[1] ? QHP_READ : QHP_WRITE;
        end
      end
      QHP_READ: begin
        mem_addr = r_q.acc;
        if (r_q.rd_pend) begin
          r_d.rd_pend = 1'b0;
        end else begin
          r_d.dout = mem_rdata;
          r_d.doe = 1'b1;
        end
        if ((r_q.mode && rd_rise) || (!r_q.mode && dir_end)) begin
          r_d.doe = 1'b0;
          r_d.st = QHP_IDLE;
        end
      end
      QHP_WRITE: begin
        // Byte latched late so it is settled at the closing edge
        r_d.wbyte = DATA_IN;
        if ((r_q.mode && wr_rise) || (!r_q.mode && dir_end)) begin
          mem_we = 1'b1;
          if (r_q.acc[ADDR_W-1:0] == ADDR_W'(MCR_ADDR)) begin
            r_d.irq_en[r_q.acc[MEM_AW-1:ADDR_W]] = r_q.wbyte[MCR_IRQ_EN_BIT];
          end
          r_d.st = QHP_IDLE;
        end
      end
      default: r_d.st = QHP_IDLE;
    endcase
    if (r_q.mode) begin
      r_d.irq = CHAN_IRQ_REQ;
      r_d.irq_oe = r_q.cur[6] ? '1 : r_q.irq_en;
    end else begin
      // Open drain: drive low only while any channel asks; unused pins driven low
      r_d.irq = '0;
      r_d.irq_oe = {3'b111, |CHAN_IRQ_REQ};
    end
  end

  // Asynchronous reset needs no running clock; all state takes constants
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r_q <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, cur: PIN_IDLE, mode: 1'b1, mode_ok: 1'b0,
               warm: 2'h0, st: QHP_IDLE,
               acc: '0, wbyte: REG_RESET, irq_en: '0, rd_pend: 1'b0, dout: REG_RESET,
               doe: 1'b0, irq: '0, irq_oe: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign DATA_OUT = r_q.dout;
  assign DATA_OE = r_q.doe;
  assign CHAN_IRQ = r_q.irq;
  assign CHAN_IRQ_OE = r_q.irq_oe;

  ////////////////////////////////////////////////////////////////////////
  property p_dir_b_low;
    @(posedge CLK) disable iff (!NRST) (r_q.mode_ok && !r_q.mode) |=>
      (CHAN_IRQ[3:1] == 3'b000 && CHAN_IRQ_OE[3:1] == 3'b111);
  endproperty
  a_dir_b_low: assert property (p_dir_b_low) else $error("Unused irq not low");

  property p_dir_a_od;
    @(posedge CLK) disable iff (!NRST) (r_q.mode_ok && !r_q.mode) |=> !CHAN_IRQ[0];
  endproperty
  a_dir_a_od: assert property (p_dir_a_od) else $error("Device irq not open drain");

  property p_force;
    @(posedge CLK) disable iff (!NRST) (r_q.mode && r_q.cur[6]) |=> CHAN_IRQ_OE == 4'hf;
  endproperty
  a_force: assert property (p_force) else $error("Forced irq not driven");

  property p_irq_en;
    @(posedge CLK) disable iff (!NRST) (r_q.mode && !r_q.cur[6]) |=> CHAN_IRQ_OE == $past(r_q.irq_en);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("Irq enable mismatch");

  property p_rd_release;
    @(posedge CLK) disable iff (!NRST) (r_q.st == QHP_READ && r_q.mode && rd_rise) |=> !DATA_OE;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("Bus not released");

  property p_rd_drive;
    @(posedge CLK) disable iff (!NRST)
      (r_q.st == QHP_IDLE && r_d.st == QHP_READ) ##1 (r_q.st == QHP_READ)[*3] |-> DATA_OE;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("Read data not driven");

  property p_wr_store;
    @(posedge CLK) disable iff (!NRST) mem_we |-> r_q.st == QHP_WRITE ##1 r_q.st == QHP_IDLE;
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("Write outside cycle");

  property p_mode_static;
    @(posedge CLK) disable iff (!NRST) r_q.mode_ok |=> $stable(r_q.mode);
  endproperty
  a_mode_static: assert property (p_mode_static) else $error("Mode changed");

  property p_no_oe_idle;
    @(posedge CLK) disable iff (!NRST) (r_q.st != QHP_READ) |=> !DATA_OE || r_q.st == QHP_READ;
  endproperty
  a_no_oe_idle: assert property (p_no_oe_idle) else $error("Data driven outside read");
endmodule

// ===== include/qhp_pkg.sv
// Shared constants for the quad UART host bus port.
// Assumes a single 40 MHz clock and eight host-visible registers per channel.
package qhp_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_CHAN = 4;
  localparam int CHAN_W = 2;
  localparam int REGS_PER_CHAN = 8;
  localparam int MEM_DEPTH = NUM_CHAN * REGS_PER_CHAN;
  localparam int MEM_AW = 5;
  localparam int MCR_IRQ_EN_BIT = 3;
  localparam int MCR_ADDR = 4;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {
    QHP_IDLE = 2'b00,
    QHP_READ = 2'b01,
    QHP_WRITE = 2'b10
  } qhp_state_e;
endpackage

// ===== verilog/qhp_regmem.sv
// Small register store for the four channels, eight bytes each.
// Assumes one clock; read data come out of a register.
module qhp_regmem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  if (AW < 1 || DW < 1) begin : g_bad_size
    $error("Store width or depth out of range");
  end
  logic [DW-1:0] mem [2**AW];
  // No reset: contents are undefined until written, as in a plain RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ===== verif/qhp_host.sv
// Host processor model for the parallel bus of the port.
// Assumes the bench sets the bus style; all pins change 2 ns after CLK rises.
module qhp_host (
  input wire logic clk,
  input wire logic strobe_mode,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [2:0] addr,
  output logic [7:0] data_in,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] sel_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr = 3'h0;
    data_in = 8'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel_n = 4'hf;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One byte access; in strobe mode none leaves every select high
  task automatic access(input logic [1:0] chan, input logic [2:0] a, input logic wr,
                        input logic none, input logic [7:0] wd, output logic [7:0] rd, output logic oe);
    @(posedge clk);
    #2;
    addr = a;
    if (wr) data_in = wd;
    if (strobe_mode) begin
      if (!none) sel_n[chan] = 1'b0;
      if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
    end else begin
      sel_n[1] = chan[0];
      sel_n[2] = chan[1];
      wr_n = ~wr;
      sel_n[0] = 1'b0;
    end
    repeat (10) @(posedge clk);
    rd = data_out;
    oe = data_oe;
    #2;
    rd_n = 1'b1;
    sel_n = 4'hf;
    if (strobe_mode) wr_n = 1'b1;
    // Data and direction held past the closing edge before release
    repeat (4) @(posedge clk);
    #2;
    wr_n = 1'b1;
    data_in = ~data_in;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the quad UART host bus port.
// Assumes the host model drives the bus; bench drives mode, reset and irq inputs.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, strobe_mode, irq_force;
  logic [3:0] irq_req, irq, irq_oe, sel_n;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, rd;
  logic rd_n, wr_n, data_oe, oe;
  int n_fail, compares;
  qhp_port i_dut (.CLK(clk), .NRST(nrst), .STROBE_MODE(strobe_mode), .ADDR(addr), .DATA_IN(data_in),
    .DATA_OUT(data_out), .DATA_OE(data_oe), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .CHAN_A_SELECT_N(sel_n[0]), .CHAN_B_SELECT_N(sel_n[1]), .CHAN_C_SELECT_N(sel_n[2]),
    .CHAN_D_SELECT_N(sel_n[3]), .IRQ_FORCE_SELECT(irq_force), .CHAN_IRQ_REQ(irq_req),
    .CHAN_IRQ(irq), .CHAN_IRQ_OE(irq_oe));
  qhp_host i_host (.clk(clk), .strobe_mode(strobe_mode), .data_out(data_out), .data_oe(data_oe),
    .addr(addr), .data_in(data_in), .rd_n(rd_n), .wr_n(wr_n), .sel_n(sel_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic m);
    nrst = 1'b0;
    strobe_mode = m;
    repeat (8) @(posedge clk);
    #2;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Channel and register isolation, including same offset on all four channels
  task automatic t_rw();
    for (int c = 0; c < 4; c++) i_host.access(c[1:0], 3'h1, 1'b1, 1'b0, 8'h5a ^ 8'(c), rd, oe);
    i_host.access(2'h0, 3'h2, 1'b1, 1'b0, 8'hc3, rd, oe);
    for (int c = 0; c < 4; c++) begin
      i_host.access(c[1:0], 3'h1, 1'b0, 1'b0, 8'h00, rd, oe);
      check("strobe read", rd, 8'h5a ^ 8'(c));
      check("strobe oe", {7'h0, oe}, 8'h01);
    end
    i_host.access(2'h0, 3'h2, 1'b0, 1'b0, 8'h00, rd, oe);
    check("strobe reg2", rd, 8'hc3);
    i_host.access(2'h0, 3'h2, 1'b0, 1'b1, 8'h00, rd, oe);
    check("no select oe", {7'h0, oe}, 8'h00);
  endtask
  task automatic t_irq();
    #2;
    irq_req = 4'b1010;
    repeat (8) @(posedge clk);
    check("irq oe default", {4'h0, irq_oe}, 8'h00);
    i_host.access(2'h1, 3'h4, 1'b1, 1'b0, 8'h08, rd, oe);
    check("irq oe enabled", {4'h0, irq_oe}, 8'h02);
    check("irq value", {4'h0, irq}, 8'h0a);
    #2;
    irq_force = 1'b1;
    repeat (8) @(posedge clk);
    check("irq oe forced", {4'h0, irq_oe}, 8'h0f);
    #2;
    irq_force = 1'b0;
    irq_req = 4'h0;
  endtask
  // Direction-style bus: single select, direction line, channel from B/C selects
  task automatic t_dir();
    do_reset(1'b0);
    for (int c = 0; c < 4; c++) i_host.access(c[1:0], 3'h3, 1'b1, 1'b0, 8'h30 + 8'(c), rd, oe);
    for (int c = 3; c >= 0; c--) begin
      i_host.access(c[1:0], 3'h3, 1'b0, 1'b0, 8'h00, rd, oe);
      check("dir read", rd, 8'h30 + 8'(c));
      check("dir oe", {7'h0, oe}, 8'h01);
    end
    #2;
    irq_req = 4'b0100;
    repeat (8) @(posedge clk);
    check("dir irq oe", {4'h0, irq_oe}, 8'h0f);
    check("dir irq value", {4'h0, irq}, 8'h00);
    #2;
    irq_req = 4'h0;
    repeat (8) @(posedge clk);
    check("dir irq idle", {4'h0, irq_oe}, 8'h0e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    // Whole run is near 20 accesses of about 20 cycles
    #200us;
    n_fail++;
    results();
  end
  initial begin
    n_fail = 0;
    compares = 0;
    nrst = 1'b0;
    strobe_mode = 1'b1;
    irq_force = 1'b0;
    irq_req = 4'h0;
    do_reset(1'b1);
    t_rw();
    t_irq();
    t_dir();
    results();
  end
endmodule
